// *** core/crs_pkg.sv ***
// Purpose: Shared constants for the comparator reference and converter control block.
// Assumes: 32-bit classic Wishbone, one register per aligned word.
// Notes:   Ladder output is expressed in 96ths of the supply (common base of 24 and 32).
package crs_pkg;
    // Register byte offsets
    localparam logic [7:0] CRS_OFS_REF_CTRL = 8'h00;
    localparam logic [7:0] CRS_OFS_ADC_CTRL = 8'h04;
    localparam logic [7:0] CRS_OFS_RES_LOW = 8'h08;
    localparam logic [7:0] CRS_OFS_RES_HIGH = 8'h0C;
    localparam logic [7:0] CRS_OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] CRS_OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] CRS_OFS_STATUS = 8'h18;

    // reference_control fields
    localparam int CRS_RC_CMP1_SEL = 7;
    localparam int CRS_RC_CMP2_SEL = 6;
    localparam int CRS_RC_RANGE_LOW = 5;
    localparam int CRS_RC_FIXED_EN = 4;
    localparam int CRS_RC_LEVEL_MSB = 3;
    localparam int CRS_RC_LEVEL_LSB = 0;
    localparam logic [7:0] CRS_RC_RESET = 8'h00;

    // Converter control fields
    localparam int CRS_AC_ON = 0;
    localparam int CRS_AC_GO = 1;
    localparam int CRS_AC_EXT_REF = 2;
    localparam int CRS_AC_RIGHT_JUST = 3;
    localparam int CRS_AC_CHAN_LSB = 4;
    localparam int CRS_AC_CHAN_MSB = 6;
    localparam logic [7:0] CRS_AC_RESET = 8'h00;

    // Interrupt bits
    localparam int CRS_IRQ_DONE = 0;
    localparam int CRS_IRQ_ABORT = 1;
    localparam logic [1:0] CRS_IRQ_RESET = 2'h0;

    // Converter and ladder figures
    localparam int CRS_RES_BITS = 10;
    localparam logic [6:0] CRS_LADDER_DENOM = 7'h60;
    localparam logic [6:0] CRS_LOW_STEP = 7'h04;
    localparam logic [6:0] CRS_HIGH_BASE = 7'h18;
    localparam logic [6:0] CRS_HIGH_STEP = 7'h03;
endpackage

// *** core/crs_sar_if.sv ***
// Purpose: Carries start, abort and result between register file and conversion engine.
// Assumes: Single clock domain.
// Notes:   done is a one-cycle pulse; result is valid in that cycle and after.
`timescale 1ns/100ps
`default_nettype none
interface crs_sar_if #(parameter int RES_BITS = 10);
    logic start;
    logic abort;
    logic busy;
    logic done;
    logic [RES_BITS-1:0] result;
    modport ctl (output start, output abort, input busy, input done, input result);
    modport eng (input start, input abort, output busy, output done, output result);
endinterface
`default_nettype wire

// *** core/crs_ladder.sv ***
// Purpose: Ladder power, reference routing and ladder ratio from reference_control.
// Assumes: Inputs are the stored register fields.
// Notes:   Ratio output is in 96ths of the supply, registered.
`timescale 1ns/100ps
`default_nettype none
module crs_ladder
    import crs_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Control fields
    input wire logic i_cmp1_sel,
    input wire logic i_cmp2_sel,
    input wire logic i_range_low,
    input wire logic [3:0] i_level,
    // Ladder controls
    output logic o_power,
    output logic o_cmp1_ladder,
    output logic o_cmp2_ladder,
    output logic [6:0] o_ratio
);
    logic [6:0] ratio_next;

    // Low range steps by 4/96 from zero; high range starts at 24/96 and steps by 3/96
    always_comb
    begin
        if (i_range_low)
            ratio_next = 7'({3'h0, i_level} * CRS_LOW_STEP);
        else
            ratio_next = 7'(CRS_HIGH_BASE + {3'h0, i_level} * CRS_HIGH_STEP);
    end

    // Divider draws current only while some comparator uses it
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_power <= 1'b0;
            o_cmp1_ladder <= 1'b0;
            o_cmp2_ladder <= 1'b0;
            o_ratio <= 7'h00;
        end
        else
        begin
            o_power <= i_cmp1_sel | i_cmp2_sel;
            o_cmp1_ladder <= i_cmp1_sel;
            o_cmp2_ladder <= i_cmp2_sel;
            o_ratio <= ratio_next;
        end
    end
endmodule // crs_ladder
`default_nettype wire

// *** core/crs_sar.sv ***
// Purpose: Successive approximation sequencer, one bit decision per clock.
// Assumes: i_cmp_above is the analog comparator answer for the trial code in o_trial.
// Notes:   An abort leaves the previous result untouched.
`timescale 1ns/100ps
`default_nettype none
module crs_sar
    import crs_pkg::*;
#(
    parameter int RES_BITS = CRS_RES_BITS
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Control side
    crs_sar_if.eng sar,
    // Analog side
    input wire logic i_cmp_above,
    output logic o_hold,
    output logic [RES_BITS-1:0] o_trial
);
    typedef enum {CRS_S_IDLE, CRS_S_HOLD, CRS_S_BITS} crs_sar_e;
    crs_sar_e state_reg;
    logic [RES_BITS-1:0] code_reg;
    logic [RES_BITS-1:0] bit_reg;

    // Width is refused at elaboration, before any logic is built on it
    if (RES_BITS < 2 || RES_BITS > 16)
    begin : g_bad_res_bits
        $error("crs_sar: RES_BITS out of range");
    end

    assign sar.busy = (state_reg != CRS_S_IDLE);
    assign o_trial = code_reg | bit_reg;

    // Sample is held for the whole decision run; abort wins over progress
    always_ff @(posedge i_clk)
    begin
        if (i_rst || sar.abort)
        begin
            state_reg <= CRS_S_IDLE;
            code_reg <= '0;
            bit_reg <= '0;
            o_hold <= 1'b0;
            sar.done <= 1'b0;
        end
        else
        begin
            sar.done <= 1'b0;
            unique case (state_reg)
                CRS_S_IDLE:
                begin
                    if (sar.start)
                    begin
                        state_reg <= CRS_S_HOLD;
                        o_hold <= 1'b1;
                    end
                end
                CRS_S_HOLD:
                begin
                    code_reg <= '0;
                    bit_reg <= {1'b1, {(RES_BITS-1){1'b0}}};
                    state_reg <= CRS_S_BITS;
                end
                CRS_S_BITS:
                begin
                    if (i_cmp_above)
                        code_reg <= code_reg | bit_reg;
                    bit_reg <= bit_reg >> 1;
                    if (bit_reg[0])
                    begin
                        state_reg <= CRS_S_IDLE;
                        o_hold <= 1'b0;
                        sar.done <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Result captures the final decision together with done
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            sar.result <= '0;
        else if (!sar.abort && state_reg == CRS_S_BITS && bit_reg[0])
            sar.result <= i_cmp_above ? (code_reg | bit_reg) : code_reg;
    end
endmodule // crs_sar
`default_nettype wire

// *** core/crs_top.sv ***
// Purpose: Comparator reference selection and converter control behind classic Wishbone.
// Assumes: i_clk 250 MHz; i_rst synchronous active high; inputs synchronous to i_clk.
// Notes:   Registers answer one cycle after the request; unmapped words read zero.
//
// The Wishbone slave port and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module crs_top
    import crs_pkg::*;
#(
    parameter int RES_BITS = CRS_RES_BITS
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // Reference controls
    input wire logic i_internal_fast_osc,
    output logic o_ladder_power,
    output logic o_cmp1_ref_input_ladder,
    output logic o_cmp2_ref_input_ladder,
    output logic o_ladder_range_low,
    output logic [3:0] o_ladder_level_select,
    output logic [6:0] o_ladder_ratio,
    output logic o_fixed_ref_enable,
    // Converter analog side
    input wire logic i_sar_cmp_above,
    output logic o_adc_enable,
    output logic o_adc_ext_ref,
    output logic [2:0] o_adc_channel,
    output logic o_adc_hold,
    output logic [RES_BITS-1:0] o_adc_trial,
    // Interrupt and wake
    input wire logic i_sleep,
    output logic o_irq,
    output logic o_wake
);
    import crs_pkg::*;

    logic [7:0] ref_ctrl_reg;
    logic [7:0] adc_ctrl_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_mask_reg;
    logic [RES_BITS-1:0] result_reg;
    logic fixed_en_reg;
    logic [31:0] rd_data;
    logic req;
    logic wr_byte0;
    logic go_write_one;
    logic go_write_zero;
    logic abort_evt;

    crs_sar_if #(.RES_BITS(RES_BITS)) sar_bus ();

    // Result pair needs at least nine bits and fits two bytes
    if (RES_BITS < 9 || RES_BITS > 16)
    begin : g_bad_res_bits
        $error("crs_top: RES_BITS must be 9..16 for the result pair");
    end

    // Word-aligned decode helper shared by read and write paths
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction

    // A request is taken once; ack drops the cycle after it is given
    assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
    assign wr_byte0 = req & i_wb_we & i_wb_sel[0];
    assign go_write_one = wr_byte0 & hit(i_wb_adr, CRS_OFS_ADC_CTRL) & i_wb_dat[CRS_AC_GO];
    assign go_write_zero = wr_byte0 & hit(i_wb_adr, CRS_OFS_ADC_CTRL) & ~i_wb_dat[CRS_AC_GO];

    // Bus acknowledge
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_wb_ack <= 1'b0;
        else
            o_wb_ack <= req;
    end

    // Reference control, fully software owned
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            ref_ctrl_reg <= CRS_RC_RESET;
        else if (wr_byte0 && hit(i_wb_adr, CRS_OFS_REF_CTRL))
            ref_ctrl_reg <= i_wb_dat[7:0];
    end

    // Converter control; go clears itself on completion or when the converter is off
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            adc_ctrl_reg <= CRS_AC_RESET;
        else
        begin
            if (wr_byte0 && hit(i_wb_adr, CRS_OFS_ADC_CTRL))
            begin
                adc_ctrl_reg <= i_wb_dat[7:0];
                // Start is refused while off or when set together with turning on
                adc_ctrl_reg[CRS_AC_GO] <= i_wb_dat[CRS_AC_GO] & adc_ctrl_reg[CRS_AC_ON] & i_wb_dat[CRS_AC_ON];
            end
            else if (sar_bus.done || !adc_ctrl_reg[CRS_AC_ON])
                adc_ctrl_reg[CRS_AC_GO] <= 1'b0;
        end
    end

    // Start on a fresh go; clearing go or switching off mid-run aborts
    assign sar_bus.start = adc_ctrl_reg[CRS_AC_GO] & ~sar_bus.busy & ~sar_bus.done;
    assign abort_evt = sar_bus.busy & (go_write_zero | ~adc_ctrl_reg[CRS_AC_ON]);
    assign sar_bus.abort = abort_evt;

    // Result pair updated only on a completed conversion
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            result_reg <= '0;
        else if (sar_bus.done)
            result_reg <= sar_bus.result;
    end

    // Sticky events; a new event beats a same-cycle write-one clear
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            irq_stat_reg <= CRS_IRQ_RESET;
        else
        begin
            if (wr_byte0 && hit(i_wb_adr, CRS_OFS_IRQ_STAT))
                irq_stat_reg <= irq_stat_reg & ~i_wb_dat[1:0];
            if (sar_bus.done)
                irq_stat_reg[CRS_IRQ_DONE] <= 1'b1;
            if (abort_evt)
                irq_stat_reg[CRS_IRQ_ABORT] <= 1'b1;
        end
    end

    // Interrupt mask
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            irq_mask_reg <= CRS_IRQ_RESET;
        else if (wr_byte0 && hit(i_wb_adr, CRS_OFS_IRQ_MASK))
            irq_mask_reg <= i_wb_dat[1:0];
    end

    // Level interrupt; wake only matters while asleep
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_irq <= 1'b0;
            o_wake <= 1'b0;
        end
        else
        begin
            o_irq <= |(irq_stat_reg & irq_mask_reg);
            o_wake <= i_sleep & |(irq_stat_reg & irq_mask_reg);
        end
    end

    // Fixed reference kept alive while the fast oscillator runs
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            fixed_en_reg <= 1'b0;
        else
            fixed_en_reg <= ref_ctrl_reg[CRS_RC_FIXED_EN] | i_internal_fast_osc;
    end
    assign o_fixed_ref_enable = fixed_en_reg;

    // Field outputs straight from the stored register
    assign o_ladder_range_low = ref_ctrl_reg[CRS_RC_RANGE_LOW];
    assign o_ladder_level_select = ref_ctrl_reg[CRS_RC_LEVEL_MSB:CRS_RC_LEVEL_LSB];
    assign o_adc_enable = adc_ctrl_reg[CRS_AC_ON];
    assign o_adc_ext_ref = adc_ctrl_reg[CRS_AC_EXT_REF];
    assign o_adc_channel = adc_ctrl_reg[CRS_AC_CHAN_MSB:CRS_AC_CHAN_LSB];

    // Read mux; result pair follows the justify bit, writes there are dropped
    always_comb
    begin
        rd_data = 32'h0000_0000;
        if (hit(i_wb_adr, CRS_OFS_REF_CTRL))
            rd_data[7:0] = ref_ctrl_reg;
        else if (hit(i_wb_adr, CRS_OFS_ADC_CTRL))
            rd_data[7:0] = adc_ctrl_reg;
        else if (hit(i_wb_adr, CRS_OFS_RES_LOW))
            rd_data[7:0] = adc_ctrl_reg[CRS_AC_RIGHT_JUST] ? result_reg[7:0]
                : 8'({result_reg[RES_BITS-9:0], 8'h00} >> (RES_BITS-8));
        else if (hit(i_wb_adr, CRS_OFS_RES_HIGH))
            rd_data[7:0] = adc_ctrl_reg[CRS_AC_RIGHT_JUST] ? 8'(result_reg >> 8)
                : result_reg[RES_BITS-1:RES_BITS-8];
        else if (hit(i_wb_adr, CRS_OFS_IRQ_STAT))
            rd_data[1:0] = irq_stat_reg;
        else if (hit(i_wb_adr, CRS_OFS_IRQ_MASK))
            rd_data[1:0] = irq_mask_reg;
        else if (hit(i_wb_adr, CRS_OFS_STATUS))
            rd_data[2:0] = {o_ladder_power, sar_bus.busy, fixed_en_reg};
    end

    // Read data registered with ack
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_wb_dat <= 32'h0000_0000;
        else if (req)
            o_wb_dat <= rd_data;
    end

    // Ladder power, routing and ratio
    crs_ladder u_ladder (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_cmp1_sel(ref_ctrl_reg[CRS_RC_CMP1_SEL]),
        .i_cmp2_sel(ref_ctrl_reg[CRS_RC_CMP2_SEL]),
        .i_range_low(ref_ctrl_reg[CRS_RC_RANGE_LOW]),
        .i_level(ref_ctrl_reg[CRS_RC_LEVEL_MSB:CRS_RC_LEVEL_LSB]),
        .o_power(o_ladder_power),
        .o_cmp1_ladder(o_cmp1_ref_input_ladder),
        .o_cmp2_ladder(o_cmp2_ref_input_ladder),
        .o_ratio(o_ladder_ratio)
    );

    // Conversion engine
    crs_sar #(.RES_BITS(RES_BITS)) u_sar (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .sar(sar_bus),
        .i_cmp_above(i_sar_cmp_above),
        .o_hold(o_adc_hold),
        .o_trial(o_adc_trial)
    );
endmodule // crs_top
`default_nettype wire

// *** testbench/crs_sva.sv ***
// Purpose: Port-level checks for crs_top.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Registered outputs are compared one cycle after their cause.
`timescale 1ns/100ps
`default_nettype none
module crs_sva
(
    // Clock, reset and bus
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic o_wb_ack,
    // Reference side
    input wire logic i_internal_fast_osc,
    input wire logic o_ladder_power,
    input wire logic o_cmp1_ref_input_ladder,
    input wire logic o_cmp2_ref_input_ladder,
    input wire logic o_ladder_range_low,
    input wire logic [3:0] o_ladder_level_select,
    input wire logic [6:0] o_ladder_ratio,
    input wire logic o_fixed_ref_enable,
    // Converter and interrupt
    input wire logic o_adc_hold,
    input wire logic i_sleep,
    input wire logic o_irq,
    input wire logic o_wake
);
    // One domain, so clock and reset are stated once
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    // Ladder power and routing
    a_power_or: assert property (o_ladder_power == (o_cmp1_ref_input_ladder | o_cmp2_ref_input_ladder))
        else $error("ladder power differs from select OR");
    a_cmp1_powered: assert property (o_cmp1_ref_input_ladder |-> o_ladder_power)
        else $error("cmp1 on ladder while unpowered");
    a_cmp2_powered: assert property (o_cmp2_ref_input_ladder |-> o_ladder_power)
        else $error("cmp2 on ladder while unpowered");
    // Ratio follows last cycle's fields; the first cycle after reset still holds zero
    a_ratio_formula: assert property (!$past(i_rst) |-> o_ladder_ratio == ($past(o_ladder_range_low) ?
        7'($past(o_ladder_level_select)) * 7'h04 : 7'h18 + 7'($past(o_ladder_level_select)) * 7'h03))
        else $error("ladder ratio wrong");
    a_osc_forces_fixed: assert property (!$past(i_rst) && $past(i_internal_fast_osc) |-> o_fixed_ref_enable)
        else $error("fixed reference off while oscillator runs");
    // Bus answer timing
    a_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("no ack one cycle after request");
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
        else $error("ack without request");
    // Conversion ends in bounded time, interrupt wakes a sleeping device
    a_hold_bounded: assert property ($rose(o_adc_hold) |-> ##[1:14] !o_adc_hold)
        else $error("hold phase too long");
    a_irq_wakes: assert property ($rose(o_irq) && $past(i_sleep) && i_sleep |-> o_wake)
        else $error("no wake on interrupt while asleep");

    c_irq: cover property ($rose(o_irq));
    c_wake: cover property (o_wake);
    c_conv_end: cover property ($fell(o_adc_hold));
    c_low_range: cover property (o_ladder_power && o_ladder_range_low);
endmodule // crs_sva
`default_nettype wire

// *** testbench/crs_analog_model.sv ***
// Purpose: Behavioural analog front end: one held input level and a comparator.
// Assumes: Answer is combinational on the trial code while the hold is on.
// Notes:   Outside the hold the answer toggles, so a stale value never helps.
`timescale 1ns/100ps
`default_nettype none
module crs_analog_model
(
    // Clock
    input wire logic i_clk,
    // Converter side
    input wire logic i_hold,
    input wire logic [9:0] i_trial,
    input wire logic [9:0] i_level,
    output logic o_above
);
    logic flip_reg = 1'b0;
    // Free toggle stands in for an unsampled input
    always @(posedge i_clk)
        flip_reg <= ~flip_reg;
    // Held level against the trial code
    assign o_above = i_hold ? (i_level >= i_trial) : flip_reg;
endmodule // crs_analog_model
`default_nettype wire

// *** testbench/crs_top_tb_top.sv ***
// Purpose: Self-checking bench for crs_top.
// Assumes: Classic Wishbone master, ack one cycle after the request.
// Notes:   Read data is checked off a queue by a separate monitor.
`timescale 1ns/100ps
`default_nettype none
module crs_top_tb_top;
    import crs_pkg::*;
    logic i_clk, i_rst, cyc, stb, we, osc, slp, o_wb_ack, pwr, c1, c2, rlow, fen, above, aen, aext, hold, o_irq, o_wake;
    logic [7:0] adr;
    logic [3:0] sel, lvl;
    logic [31:0] wdat, o_wb_dat, seed;
    logic [6:0] ratio;
    logic [2:0] chan;
    logic [9:0] trial, target;
    logic [31:0] expq[$];
    int miscompares, check_count;

    crs_top u_crs_top (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
        .i_internal_fast_osc(osc), .o_ladder_power(pwr), .o_cmp1_ref_input_ladder(c1),
        .o_cmp2_ref_input_ladder(c2), .o_ladder_range_low(rlow), .o_ladder_level_select(lvl),
        .o_ladder_ratio(ratio), .o_fixed_ref_enable(fen), .i_sar_cmp_above(above), .o_adc_enable(aen),
        .o_adc_ext_ref(aext), .o_adc_channel(chan), .o_adc_hold(hold), .o_adc_trial(trial),
        .i_sleep(slp), .o_irq(o_irq), .o_wake(o_wake));
    crs_analog_model u_crs_analog_model (.i_clk(i_clk), .i_hold(hold), .i_trial(trial), .i_level(target),
        .o_above(above));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // One classic cycle; held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge i_clk);
        while (o_wb_ack !== 1'b1)
            @(posedge i_clk);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        wb(1'b0, a, 32'h0000_0000);
    endtask

    // Bounded wait for the hold phase to end, then for status and interrupt
    task automatic wait_conv();
        int n;
        n = 0;
        repeat (2) @(posedge i_clk);
        while (hold === 1'b1 && n < 40)
        begin
            @(posedge i_clk);
            n++;
        end
        // Hold spans the sample cycle plus one per bit; two of those pass before counting
        chk(n, CRS_RES_BITS);
        repeat (3) @(posedge i_clk);
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Monitor: each read answer is matched with the oldest note
    always @(posedge i_clk)
        if (o_wb_ack === 1'b1 && we === 1'b0)
            chk(o_wb_dat, expq.pop_front());

    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    // Ceiling well above the few hundred cycles the sequence needs
    initial
    begin
        repeat (5000) @(posedge i_clk);
        miscompares++;
        print_verdict();
    end

    initial
    begin
        logic [31:0] r, v, lo, hi, ctl;
        {i_rst, cyc, stb, we, osc, slp, adr, wdat, target} = '0;
        i_rst = 1'b1;
        sel = 4'hf;
        seed = 32'h0000_725E;
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        // Every word reads zero after reset, the unmapped one included
        for (int a = 0; a < 8; a++)
            rd(8'(a * 4), 32'h0000_0000);
        // Every level once, select taken from the level's low two bits, random range, fixed enable and oscillator
        for (int i = 0; i < 16; i++)
        begin
            r = xs();
            v = {24'h0, i[1:0], r[5:4], i[3:0]};
            osc <= r[8];
            wb(1'b1, CRS_OFS_REF_CTRL, v);
            rd(CRS_OFS_REF_CTRL, v);
            repeat (2) @(posedge i_clk);
            chk(c1, v[7]);
            chk(c2, v[6]);
            chk(pwr, v[7] | v[6]);
            chk(rlow, v[5]);
            chk(lvl, v[3:0]);
            chk(ratio, v[5] ? 7'(v[3:0]) * 7'h04 : 7'h18 + 7'(v[3:0]) * 7'h03);
            chk(fen, v[4] | r[8]);
            rd(CRS_OFS_STATUS, {29'h0, v[7] | v[6], 1'b0, v[4] | r[8]});
        end
        // Right justified on channel 1 masked in asleep, then left justified external ref masked out
        for (int k = 0; k < 2; k++)
        begin
            target <= 10'(xs());
            ctl = k ? 32'h25 : 32'h19;
            slp <= !k[0];
            wb(1'b1, CRS_OFS_IRQ_MASK, {31'h0, !k[0]});
            wb(1'b1, CRS_OFS_ADC_CTRL, ctl);
            wb(1'b1, CRS_OFS_ADC_CTRL, ctl | 32'h2);
            wait_conv();
            lo = k ? {24'h0, target[1:0], 6'h00} : {24'h0, target[7:0]};
            hi = k ? {24'h0, target[9:2]} : {30'h0, target[9:8]};
            chk(aext, ctl[2]);
            chk(chan, ctl[6:4]);
            chk(aen, ctl[0]);
            chk(o_irq, !k[0]);
            chk(o_wake, !k[0]);
            rd(CRS_OFS_IRQ_STAT, 32'h1);
            rd(CRS_OFS_ADC_CTRL, ctl);
            wb(1'b1, CRS_OFS_RES_LOW, 32'hffff_ffff);
            wb(1'b1, CRS_OFS_RES_HIGH, 32'hffff_ffff);
            rd(CRS_OFS_RES_LOW, lo);
            rd(CRS_OFS_RES_HIGH, hi);
            wb(1'b1, CRS_OFS_IRQ_STAT, 32'h1);
            repeat (2) @(posedge i_clk);
            chk(o_irq, 1'b0);
        end
        // Abort in mid-conversion keeps the old result; go with power-on in one write is refused
        target <= ~target;
        wb(1'b1, CRS_OFS_ADC_CTRL, 32'h27);
        repeat (3) @(posedge i_clk);
        wb(1'b1, CRS_OFS_ADC_CTRL, 32'h0);
        wb(1'b1, CRS_OFS_ADC_CTRL, 32'h3);
        repeat (3) @(posedge i_clk);
        chk(hold, 1'b0);
        rd(CRS_OFS_IRQ_STAT, 32'h2);
        rd(CRS_OFS_RES_HIGH, hi);
        rd(CRS_OFS_ADC_CTRL, 32'h1);
        // Second reset in mid-run clears the reference control again
        i_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(CRS_OFS_REF_CTRL, 32'h0);
        // Ladder falls back to unpowered, fixed routing and the high-range base after reset
        chk(pwr, 1'b0);
        chk(c1, 1'b0);
        chk(c2, 1'b0);
        chk(ratio, 7'h18);
        chk(fen, osc);
        repeat (2) @(posedge i_clk);
        print_verdict();
    end
endmodule // crs_top_tb_top
bind crs_top crs_sva u_crs_sva (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .o_wb_ack(o_wb_ack), .i_internal_fast_osc(i_internal_fast_osc), .o_ladder_power(o_ladder_power),
    .o_cmp1_ref_input_ladder(o_cmp1_ref_input_ladder), .o_cmp2_ref_input_ladder(o_cmp2_ref_input_ladder),
    .o_ladder_range_low(o_ladder_range_low), .o_ladder_level_select(o_ladder_level_select),
    .o_ladder_ratio(o_ladder_ratio), .o_fixed_ref_enable(o_fixed_ref_enable), .o_adc_hold(o_adc_hold),
    .i_sleep(i_sleep), .o_irq(o_irq), .o_wake(o_wake));
`default_nettype wire
